/* design/ari_consts.svh */
// Offsets, field positions, reset values and counts of the reset and init block
`ifndef ARI_CONSTS_SVH
`define ARI_CONSTS_SVH

// ==========================================
// Register port
`define ARI_AW          8
`define ARI_DW          24
`define ARI_CFG_ADDR    8'h00
`define ARI_CMD_ADDR    8'h04
`define ARI_FIFO_ADDR   8'h08
`define ARI_STAT_ADDR   8'h0c
`define ARI_OFS_PAGE    3'h2
`define ARI_GAIN_PAGE   3'h3
`define ARI_CSR_PAGE    3'h4

// ==========================================
// Reset values and configuration fields
`define ARI_CFG_RST     24'h000040
`define ARI_OFS_RST     24'h000000
`define ARI_GAIN_RST    24'h400000
`define ARI_CSR_RST     24'h000000
`define ARI_CFG_WMASK   24'h37ffb0
`define ARI_CFG_RS      7
`define ARI_CFG_RV      6
`define ARI_CFG_DP_LSB  12
`define ARI_CFG_DP_MSB  15

// ==========================================
// Master clock and power-on timing
`define ARI_POR_CYCLES  2006
`define ARI_POR_CW      11
`define ARI_MCLK_MIN_HZ 30000
`define ARI_MCLK_NOM_HZ 32768
`define ARI_MCLK_MAX_HZ 100000

// ==========================================
// Serial port
`define ARI_INIT_ONES   4'hf
`define ARI_BYTE_ONES   8'hff
`define ARI_BYTE_INIT   8'hfe
`define ARI_CMD_CONV    7

`endif

/* design/ari_pkg.sv */
// Types shared by the reset and init block
package ari_pkg;
	typedef enum logic [1:0] {por_wait_osc, por_count, por_release} ari_por_state_t;
	typedef enum logic {pm_command, pm_data} ari_port_mode_t;
endpackage

/* design/ari_mem_if.sv */
// Port bundle between the controller and the result memory
`timescale 1ns/100ps
`default_nettype none
interface ari_mem_if #(parameter int W = 24, parameter int AW = 4);
	logic          wr_en;
	logic [AW-1:0] wr_addr;
	logic [W-1:0]  wr_data;
	logic          rd_en;
	logic [AW-1:0] rd_addr;
	logic [W-1:0]  rd_data;
	modport ctrl (output wr_en, wr_addr, wr_data, rd_en, rd_addr, input rd_data);
	modport mem  (input wr_en, wr_addr, wr_data, rd_en, rd_addr, output rd_data);
endinterface // ari_mem_if
`default_nettype wire

/* design/ari_fifo_mem.sv */
// Storage for the conversion result words, registered read
`timescale 1ns/100ps
`default_nettype none
module ari_fifo_mem #(
	parameter int W = 24,
	parameter int D = 16
) (
	// Clock
	input wire logic clk,
	// Memory access
	ari_mem_if.mem   m
);
	logic [W-1:0] ram [D];

	always_ff @(posedge clk) begin
		if (m.wr_en) begin
			ram[m.wr_addr] <= m.wr_data;
		end
	end

	always_ff @(posedge clk) begin
		if (m.rd_en) begin
			m.rd_data <= ram[m.rd_addr];
		end
	end
endmodule // ari_fifo_mem
`default_nettype wire

/* design/ari_reset_init.sv */
// Power-on reset, register initialisation, sequencer, result FIFO and port framing
// Notes on behaviour
// - Held in reset until oscillator runs and 2006 master clocks are counted.
// - During power-on timeout serial port resets and reset-valid flag is set.
// - Reset loads configuration 000040, offsets and setups zero, gains 400000.
// - After reset the serial port sits in command mode awaiting a command.
// - Writing one to the system-reset bit starts a full reset anytime.
// - Reset-valid flag stays set until software reads the configuration.
// - First result after a channel change is valid and kept.
// - Master clock lies between 30 and 100 kHz, nominally 32.768 kHz.
// - Command register is eight bits, every other register 24 bits.
// - Channel setups form a sequencer over up to 16 logical channels.
// - Read-only result FIFO, 24-bit words, sixteen deep, kept until read.
// - Separate gain and offset calibration register per physical channel.
// - Eight filter rate settings and a 2-bit output latch.
// - In command mode the first eight bits form the command.
// - Fifteen all-ones bytes then the init byte return to command mode.
//
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "ari_consts.svh"
module ari_reset_init import ari_pkg::*; #(
	parameter int FIFO_DEPTH = 16,
	parameter int NUM_CH     = 8
) (
	// System clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// Master clock domain
	input  wire logic        xin_clk,
	input  wire logic        osc_running,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [23:0] reg_wdata,
	input  wire logic        reg_we,
	input  wire logic        reg_re,
	output logic      [23:0] reg_rdata,
	// Serial port pins
	input  wire logic        sp_cs_n,
	input  wire logic        sp_sclk,
	input  wire logic        sp_sdi,
	// Command output
	output logic             cmd_valid,
	output logic      [7:0]  cmd_byte,
	output logic             port_data_mode,
	// Conversion results
	input  wire logic        conv_valid,
	input  wire logic [23:0] conv_data,
	// Current logical channel and reset-mode flag
	output logic      [1:0]  lc_latch,
	output logic      [2:0]  lc_phys,
	output logic      [2:0]  lc_rate,
	output logic      [2:0]  lc_gain,
	output logic             lc_unipolar,
	output logic             in_reset
);
	localparam int FAW = $clog2(FIFO_DEPTH);
	localparam logic [`ARI_POR_CW-1:0] POR_LAST = `ARI_POR_CW'(`ARI_POR_CYCLES - 1);

	// ==========================================
	// Master clock domain
	logic           xr_s1, xr_s2, ox_s1, ox_s2, por_done_x;
	logic [`ARI_POR_CW-1:0] por_cnt_r;
	ari_por_state_t por_st_r;

	always_ff @(posedge xin_clk or negedge resetn) begin
		if (!resetn) begin
			xr_s1 <= 1'b0;
			xr_s2 <= 1'b0;
		end else begin
			xr_s1 <= 1'b1;
			xr_s2 <= xr_s1;
		end
	end

	always_ff @(posedge xin_clk or negedge xr_s2) begin
		if (!xr_s2) begin
			ox_s1 <= 1'b0;
			ox_s2 <= 1'b0;
		end else begin
			ox_s1 <= osc_running;
			ox_s2 <= ox_s1;
		end
	end

	// Count in master clocks so the wait scales with the clock rate
	always_ff @(posedge xin_clk or negedge xr_s2) begin
		if (!xr_s2) begin
			por_st_r   <= por_wait_osc;
			por_cnt_r  <= '0;
			por_done_x <= 1'b0;
		end else begin
			case (por_st_r)
				por_wait_osc: begin
					if (ox_s2) begin
						por_st_r <= por_count;
					end
				end
				por_count: begin
					if (!ox_s2) begin
						por_st_r  <= por_wait_osc;
						por_cnt_r <= '0;
					end else if (por_cnt_r == POR_LAST) begin
						por_st_r   <= por_release;
						por_done_x <= 1'b1;
					end else begin
						por_cnt_r <= por_cnt_r + 1'b1;
					end
				end
				por_release: begin
					por_done_x <= 1'b1;
				end
				default: begin
					por_st_r <= por_wait_osc;
				end
			endcase
		end
	end

	por_term_a: assert property (@(posedge xin_clk) disable iff (!xr_s2)
		por_st_r == por_count && ox_s2 && por_cnt_r == POR_LAST |=> por_done_x)
		else $error("power-on release missed terminal count");
	por_early_a: assert property (@(posedge xin_clk) disable iff (!xr_s2)
		por_st_r != por_release |-> !por_done_x)
		else $error("power-on release before count elapsed");

	// ==========================================
	// System reset and crossing
	logic sr_s1, rst_n, pd_s1, pd_s2;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sr_s1 <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			sr_s1 <= 1'b1;
			rst_n <= sr_s1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pd_s1 <= 1'b0;
			pd_s2 <= 1'b0;
		end else begin
			pd_s1 <= por_done_x;
			pd_s2 <= pd_s1;
		end
	end

	// ==========================================
	// Register decode
	logic        hold, soft_rst, init, aligned;
	logic        cfg_wr, cfg_rd, fifo_rd, stat_rd, in_rs;
	logic [2:0]  page, idx;
	logic [23:0] cfg_r;
	logic [23:0] ofs_r  [NUM_CH];
	logic [23:0] gain_r [NUM_CH];
	logic [23:0] csr_r  [NUM_CH];

	assign hold     = !pd_s2;
	assign aligned  = reg_addr[1:0] == 2'h0;
	assign page     = reg_addr[7:5];
	assign idx      = reg_addr[4:2];
	assign cfg_wr   = reg_we && reg_addr == `ARI_CFG_ADDR;
	assign cfg_rd   = reg_re && reg_addr == `ARI_CFG_ADDR;
	assign stat_rd  = reg_re && reg_addr == `ARI_STAT_ADDR;
	assign soft_rst = cfg_wr && reg_wdata[`ARI_CFG_RS] && !hold;
	assign init     = hold || soft_rst;
	assign in_rs    = cfg_r[`ARI_CFG_RS];
	assign in_reset = hold || in_rs;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_r <= `ARI_CFG_RST;
		end else if (init) begin
			cfg_r <= `ARI_CFG_RST;
			cfg_r[`ARI_CFG_RS] <= soft_rst;
		end else if (cfg_wr) begin
			cfg_r <= (cfg_r & ~`ARI_CFG_WMASK) | (reg_wdata & `ARI_CFG_WMASK);
		end else if (cfg_rd) begin
			cfg_r[`ARI_CFG_RV] <= 1'b0;
		end
	end

	// Calibration and channel-setup words; writes ignored in reset mode
	for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				ofs_r[g]  <= `ARI_OFS_RST;
				gain_r[g] <= `ARI_GAIN_RST;
				csr_r[g]  <= `ARI_CSR_RST;
			end else if (init) begin
				ofs_r[g]  <= `ARI_OFS_RST;
				gain_r[g] <= `ARI_GAIN_RST;
				csr_r[g]  <= `ARI_CSR_RST;
			end else if (reg_we && aligned && !in_rs && idx == 3'(g)) begin
				if (page == `ARI_OFS_PAGE) begin
					ofs_r[g] <= reg_wdata;
				end
				if (page == `ARI_GAIN_PAGE) begin
					gain_r[g] <= reg_wdata;
				end
				if (page == `ARI_CSR_PAGE) begin
					csr_r[g] <= reg_wdata;
				end
			end
		end
	end

	sequence soft_req_s;
		soft_rst;
	endsequence
	sequence soft_state_s;
		in_rs && cfg_r[`ARI_CFG_RV] && gain_r[0] == `ARI_GAIN_RST && ofs_r[0] == `ARI_OFS_RST;
	endsequence
	soft_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
		soft_req_s |=> soft_state_s)
		else $error("system-reset write did not reload registers");
	por_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		hold ##1 hold |-> cfg_r == `ARI_CFG_RST && csr_r[NUM_CH-1] == `ARI_CSR_RST)
		else $error("registers not at reset values during power-on");
	rv_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
		cfg_r[`ARI_CFG_RV] && !cfg_rd && !cfg_wr |=> cfg_r[`ARI_CFG_RV])
		else $error("reset-valid flag dropped without a read");
	rv_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
		cfg_rd && !init |=> !cfg_r[`ARI_CFG_RV])
		else $error("reset-valid flag not cleared by read");
	rs_release_a: assert property (@(posedge clk) disable iff (!rst_n)
		cfg_wr && !reg_wdata[`ARI_CFG_RS] && !hold |=> !in_reset)
		else $error("writing zero did not leave reset mode");

	// ==========================================
	// Serial port framing
	logic [2:0] pin_s1, pin_s2, pin_s3;
	logic [7:0] sh_r, sh_nxt;
	logic [2:0] bit_cnt_r;
	logic [3:0] ones_r;
	logic       cs_act, sclk_rise, byte_done, init_hit, cmd_take, cmd_ptr_ld;
	ari_port_mode_t mode_r;

	function automatic logic cmd_ok(input logic [7:0] b);
		if (b[`ARI_CMD_CONV]) begin
			cmd_ok = !(b[2:0] == 3'h3 || b[2:0] == 3'h4 || b[2:0] == 3'h7);
		end else begin
			cmd_ok = !(b[2:0] == 3'h0 || b[2:0] == 3'h6 || b[2:0] == 3'h7);
		end
	endfunction

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1 <= 3'h1;
			pin_s2 <= 3'h1;
			pin_s3 <= 3'h1;
		end else begin
			pin_s1 <= {sp_sdi, sp_sclk, sp_cs_n};
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
		end
	end

	assign cs_act     = !pin_s2[0];
	assign sclk_rise  = pin_s2[1] && !pin_s3[1] && cs_act;
	assign sh_nxt     = {sh_r[6:0], pin_s2[2]};
	assign byte_done  = sclk_rise && bit_cnt_r == 3'h7;
	assign init_hit   = byte_done && sh_nxt == `ARI_BYTE_INIT && ones_r == `ARI_INIT_ONES;
	assign cmd_take   = byte_done && mode_r == pm_command && !init_hit && cmd_ok(sh_nxt);
	assign cmd_ptr_ld = cmd_take && sh_nxt[`ARI_CMD_CONV];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sh_r      <= 8'h00;
			bit_cnt_r <= 3'h0;
		end else if (init || !cs_act) begin
			bit_cnt_r <= 3'h0;
		end else if (sclk_rise) begin
			sh_r      <= sh_nxt;
			bit_cnt_r <= bit_cnt_r + 3'h1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ones_r <= 4'h0;
		end else if (init) begin
			ones_r <= 4'h0;
		end else if (byte_done) begin
			if (sh_nxt != `ARI_BYTE_ONES) begin
				ones_r <= 4'h0;
			end else if (ones_r != `ARI_INIT_ONES) begin
				ones_r <= ones_r + 4'h1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_r    <= pm_command;
			cmd_valid <= 1'b0;
			cmd_byte  <= 8'h00;
		end else if (init) begin
			mode_r    <= pm_command;
			cmd_valid <= 1'b0;
		end else begin
			cmd_valid <= 1'b0;
			if (init_hit) begin
				mode_r <= pm_command;
			end else if (cmd_take) begin
				cmd_valid <= 1'b1;
				cmd_byte  <= sh_nxt;
				if (!(sh_nxt[`ARI_CMD_CONV] && sh_nxt[2:0] != 3'h0)) begin
					mode_r <= pm_data;
				end
			end else if (mode_r == pm_data && !cs_act) begin
				mode_r <= pm_command;
			end
		end
	end

	assign port_data_mode = mode_r == pm_data;

	port_cmd_a: assert property (@(posedge clk) disable iff (!rst_n)
		init |=> !port_data_mode && !cmd_valid)
		else $error("port not in command mode after reset");
	cmd_accept_a: assert property (@(posedge clk) disable iff (!rst_n)
		cmd_take && !init |=> cmd_valid && cmd_byte == $past(sh_nxt))
		else $error("command byte not taken");
	init_seq_a: assert property (@(posedge clk) disable iff (!rst_n)
		init_hit && !init |=> !port_data_mode && !cmd_valid)
		else $error("init sequence did not return to command mode");

	// ==========================================
	// Channel sequencer
	logic [3:0]  seq_ptr_r, depth;
	logic [23:0] csr_sel;
	logic [11:0] lc_cur;

	assign depth   = cfg_r[`ARI_CFG_DP_MSB:`ARI_CFG_DP_LSB];
	assign csr_sel = csr_r[seq_ptr_r[3:1]];
	assign lc_cur  = seq_ptr_r[0] ? csr_sel[11:0] : csr_sel[23:12];

	// No result is discarded after a channel change
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			seq_ptr_r <= 4'h0;
		end else if (init) begin
			seq_ptr_r <= 4'h0;
		end else if (cmd_ptr_ld) begin
			seq_ptr_r <= sh_nxt[6:3];
		end else if (conv_valid) begin
			seq_ptr_r <= (seq_ptr_r >= depth) ? 4'h0 : seq_ptr_r + 4'h1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			{lc_latch, lc_phys, lc_rate, lc_gain, lc_unipolar} <= 12'h000;
		end else begin
			{lc_latch, lc_phys, lc_rate, lc_gain, lc_unipolar} <= lc_cur;
		end
	end

	seq_wrap_a: assert property (@(posedge clk) disable iff (!rst_n)
		conv_valid && !init && !cmd_ptr_ld && seq_ptr_r >= depth |=> seq_ptr_r == 4'h0)
		else $error("sequencer did not wrap at depth");

	// ==========================================
	// Result FIFO
	ari_mem_if #(.W(24), .AW(FAW)) mif ();
	logic [FAW:0]  wr_ptr_r, rd_ptr_r, count;
	logic          full, push, pop, ovf_r, sel_fifo_r;
	logic [23:0]   rdata_r;

	assign count   = wr_ptr_r - rd_ptr_r;
	assign full    = count == (FAW+1)'(FIFO_DEPTH);
	assign push    = conv_valid && !full && !init;
	assign fifo_rd = reg_re && reg_addr == `ARI_FIFO_ADDR;
	assign pop     = fifo_rd && count != '0 && !init;

	assign mif.wr_en   = push;
	assign mif.wr_addr = wr_ptr_r[FAW-1:0];
	assign mif.wr_data = conv_data;
	assign mif.rd_en   = pop;
	assign mif.rd_addr = rd_ptr_r[FAW-1:0];

	ari_fifo_mem #(.W(24), .D(FIFO_DEPTH)) u_mem (
		.clk (clk),
		.m   (mif.mem)
	);

	// Words stay until popped by a read
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
		end else if (init) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
			end
		end
	end

	// Overflow set wins over the clearing read
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ovf_r <= 1'b0;
		end else if (init) begin
			ovf_r <= 1'b0;
		end else if (conv_valid && full) begin
			ovf_r <= 1'b1;
		end else if (stat_rd) begin
			ovf_r <= 1'b0;
		end
	end

	fifo_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
		!pop && !init |=> count >= $past(count))
		else $error("result word lost without a read");

	// ==========================================
	// Read data
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_r    <= 24'h000000;
			sel_fifo_r <= 1'b0;
		end else begin
			rdata_r    <= 24'h000000;
			sel_fifo_r <= pop;
			if (reg_re && aligned) begin
				case (page)
					`ARI_OFS_PAGE:  rdata_r <= ofs_r[idx];
					`ARI_GAIN_PAGE: rdata_r <= gain_r[idx];
					`ARI_CSR_PAGE:  rdata_r <= csr_r[idx];
					default: begin
						if (reg_addr == `ARI_CFG_ADDR) begin
							rdata_r <= cfg_r;
						end else if (reg_addr == `ARI_CMD_ADDR) begin
							rdata_r <= {16'h0000, cmd_byte};
						end else if (reg_addr == `ARI_STAT_ADDR) begin
							rdata_r <= {16'h0000, count, in_reset, port_data_mode, ovf_r};
						end
					end
				endcase
			end
		end
	end

	assign reg_rdata = sel_fifo_r ? mif.rd_data : rdata_r;
endmodule // ari_reset_init
`default_nettype wire

/* sim/ari_host_model.sv */
// Serial host model that drives the command port pins
`timescale 1ns/100ps
`default_nettype none
module ari_host_model (
	// Serial port pins
	output logic sp_cs_n,
	output logic sp_sclk,
	output logic sp_sdi
);
	// ==========================================
	// Idle levels
	initial begin
		sp_cs_n = 1'b1;
		sp_sclk = 1'b0;
		sp_sdi  = 1'b0;
	end

	// ==========================================
	// Framing and byte shifting
	task automatic frame_begin();
		sp_cs_n = 1'b0;
		#61;
	endtask

	task automatic send_byte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			sp_sdi = b[i];
			#60;
			sp_sclk = !sp_sclk;
			#250;
			sp_sclk = !sp_sclk;
			// Hold time over: stale bit must not linger
			sp_sdi = ~sp_sdi;
			#200;
		end
	endtask

	task automatic frame_end();
		#100;
		sp_cs_n = 1'b1;
		sp_sdi  = ~sp_sdi;
	endtask

	task automatic init_seq();
		repeat (15) send_byte(8'hff);
		send_byte(8'hfe);
	endtask
endmodule // ari_host_model
`default_nettype wire

/* sim/test_adc_reset_and_register_init.sv */
// Self-checking bench for the reset and init block
`timescale 1ns/100ps
`default_nettype none
`include "ari_consts.svh"
module test_adc_reset_and_register_init;
	logic        clk;
	logic        resetn;
	logic        xin_clk;
	logic        osc_running;
	logic [7:0]  reg_addr;
	logic [23:0] reg_wdata;
	logic        reg_we;
	logic        reg_re;
	logic [23:0] reg_rdata;
	logic        sp_cs_n;
	logic        sp_sclk;
	logic        sp_sdi;
	logic        cmd_valid;
	logic [7:0]  cmd_byte;
	logic        port_data_mode;
	logic        conv_valid;
	logic [23:0] conv_data;
	logic [1:0]  lc_latch;
	logic [2:0]  lc_phys;
	logic [2:0]  lc_rate;
	logic [2:0]  lc_gain;
	logic        lc_unipolar;
	logic        in_reset;
	logic [11:0] lc_word;
	logic [23:0] rd_q[$];
	logic [7:0]  cmd_q[$];
	logic [23:0] fifo_q[$];
	logic        re_seen = 1'b0;
	logic [23:0] val;
	logic [23:0] csr_v;
	int          failures;
	int          n_compared;
	int          seed;
	int          k;

	assign lc_word = {lc_latch, lc_phys, lc_rate, lc_gain, lc_unipolar};

	ari_reset_init #(.FIFO_DEPTH(16), .NUM_CH(8)) ari_reset_init_inst (
		.clk(clk), .resetn(resetn), .xin_clk(xin_clk), .osc_running(osc_running),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
		.reg_rdata(reg_rdata), .sp_cs_n(sp_cs_n), .sp_sclk(sp_sclk), .sp_sdi(sp_sdi),
		.cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .port_data_mode(port_data_mode),
		.conv_valid(conv_valid), .conv_data(conv_data), .lc_latch(lc_latch),
		.lc_phys(lc_phys), .lc_rate(lc_rate), .lc_gain(lc_gain),
		.lc_unipolar(lc_unipolar), .in_reset(in_reset));

	ari_host_model ari_host_model_inst (.sp_cs_n(sp_cs_n), .sp_sclk(sp_sclk), .sp_sdi(sp_sdi));

	// ==========================================
	// Clocks
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		xin_clk = 1'b0;
		#1.3;
		forever #3 xin_clk = ~xin_clk;
	end

	// ==========================================
	// Compare, bus and closing tasks
	task automatic bad(input string msg);
		failures++;
		$display("BAD %0t %s", $time, msg);
	endtask
	task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string msg);
		n_compared++;
		if (got !== exp) bad(msg);
	endtask
	task automatic wr(input logic [7:0] a, input logic [23:0] d);
		@(posedge clk);
		reg_we    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_we <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [23:0] e);
		@(posedge clk);
		reg_re   <= 1'b1;
		reg_addr <= a;
		rd_q.push_back(e);
		@(posedge clk);
		reg_re <= 1'b0;
	endtask
	task automatic conv(input logic [23:0] d);
		@(posedge clk);
		conv_valid <= 1'b1;
		conv_data  <= d;
		@(posedge clk);
		conv_valid <= 1'b0;
	endtask
	task automatic test_done();
		if (failures == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ==========================================
	// Result watcher
	always @(posedge clk) begin
		if (re_seen) begin
			if (rd_q.size() == 0) bad("read data without request");
			else chk(reg_rdata, rd_q.pop_front(), "read data");
		end
		re_seen = reg_re;
		if (cmd_valid === 1'b1) begin
			if (cmd_q.size() == 0) bad("command pulse not expected");
			else chk(24'(cmd_byte), 24'(cmd_q.pop_front()), "command byte");
		end
	end

	// ==========================================
	// Main sequence
	initial begin
		seed = 2;
		failures = 0;
		n_compared = 0;
		resetn = 1'b0;
		osc_running = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 24'h000000;
		reg_we = 1'b0;
		reg_re = 1'b0;
		conv_valid = 1'b0;
		conv_data = 24'h000000;
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		repeat (3000) @(posedge clk);
		chk(24'(in_reset), 24'h1, "released without oscillator");
		// Oscillator drops out once mid-count, so the count must restart
		for (int p = 0; p < 3; p++) begin
			@(posedge xin_clk);
			osc_running <= p != 1;
			if (p == 0) repeat (300 + ($random(seed) & 255)) @(posedge xin_clk);
			if (p == 1) begin
				repeat (10) @(posedge xin_clk);
				chk(24'(in_reset), 24'h1, "released during dropout");
			end
		end
		repeat (2004) @(posedge xin_clk);
		chk(24'(in_reset), 24'h1, "released before count");
		for (k = 0; k < 20 && in_reset !== 1'b0; k++) @(posedge xin_clk);
		if (in_reset !== 1'b0) begin
			bad("no release after count");
			test_done();
		end
		@(posedge clk);
		chk(24'(port_data_mode), 24'h0, "port not in command mode");
		rd(`ARI_CFG_ADDR, `ARI_CFG_RST);
		rd(`ARI_CFG_ADDR, 24'h000000);
		for (int i = 0; i < 8; i++) begin
			rd(8'h40 + 8'(4 * i), `ARI_OFS_RST);
			rd(8'h60 + 8'(4 * i), `ARI_GAIN_RST);
			rd(8'h80 + 8'(4 * i), `ARI_CSR_RST);
		end
		val = 24'($random(seed));
		wr(8'h6c, val);
		wr(8'h4c, ~val);
		rd(8'h6c, val);
		rd(8'h4c, ~val);
		rd(8'h68, `ARI_GAIN_RST);
		rd(8'h20, 24'h000000);
		wr(`ARI_CMD_ADDR, 24'hffffff);
		rd(`ARI_CMD_ADDR, 24'h000000);
		csr_v = 24'($random(seed));
		wr(8'h80, csr_v);
		wr(`ARI_CFG_ADDR, 24'h001000);
		@(posedge clk);
		#1;
		chk(24'(lc_word), 24'(csr_v[23:12]), "first logical channel");
		for (int i = 0; i < 17; i++) begin
			val = 24'($random(seed));
			if (i < 16) fifo_q.push_back(val);
			conv(val);
			@(posedge clk);
			#1;
			chk(24'(lc_word), 24'(i % 2 == 0 ? csr_v[11:0] : csr_v[23:12]), "sequencer");
		end
		rd(`ARI_STAT_ADDR, 24'h000081);
		rd(`ARI_STAT_ADDR, 24'h000080);
		for (int i = 0; i < 16; i++) rd(`ARI_FIFO_ADDR, fifo_q.pop_front());
		rd(`ARI_FIFO_ADDR, 24'h000000);
		ari_host_model_inst.frame_begin();
		ari_host_model_inst.send_byte(8'h00);
		chk(24'(port_data_mode), 24'h0, "bad command taken");
		cmd_q.push_back(8'h01);
		ari_host_model_inst.send_byte(8'h01);
		chk(24'(port_data_mode), 24'h1, "no data mode");
		ari_host_model_inst.init_seq();
		chk(24'(port_data_mode), 24'h0, "init sequence ignored");
		cmd_q.push_back(8'h80);
		ari_host_model_inst.send_byte(8'h80);
		chk(24'(port_data_mode), 24'h1, "no data mode");
		rd(`ARI_CMD_ADDR, 24'h000080);
		wr(`ARI_CFG_ADDR, 24'h000080);
		@(posedge clk);
		#1;
		chk(24'(in_reset), 24'h1, "soft reset not entered");
		chk(24'(port_data_mode), 24'h0, "port not reset");
		wr(8'h6c, 24'h123456);
		rd(8'h6c, `ARI_GAIN_RST);
		rd(8'h80, `ARI_CSR_RST);
		rd(`ARI_STAT_ADDR, 24'h000004);
		rd(`ARI_CFG_ADDR, 24'h0000c0);
		wr(`ARI_CFG_ADDR, 24'h000000);
		rd(`ARI_CFG_ADDR, 24'h000000);
		ari_host_model_inst.frame_end();
		repeat (4) @(posedge clk);
		chk(24'(in_reset), 24'h0, "soft reset not left");
		if (rd_q.size() != 0 || cmd_q.size() != 0) bad("expected results missing");
		test_done();
	end
endmodule // test_adc_reset_and_register_init
`default_nettype wire
